/* File: logic/storm_cfg_pkg.sv */
// Purpose: constants for the global speed / VID / storm-threshold register slice
// Assumes: 8-bit management register port, 10 MHz core clock
// Notes:   offsets are the register numbers of the management map
package storm_cfg_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] OFS_SPEED_VID_STORM_HI = 8'h06;
  localparam logic [7:0] OFS_STORM_RATE_LOW     = 8'h07;
  localparam logic [7:0] OFS_FACTORY_TEST_A     = 8'h08;
  localparam logic [7:0] OFS_FACTORY_TEST_B     = 8'h09;
  localparam logic [7:0] OFS_FACTORY_TEST_C     = 8'h0A;
  localparam logic [7:0] OFS_MISC_GLOBAL_CONFIG = 8'h0B;

  // ==========================================================================
  // field positions
  localparam int BIT_P5_SPEED_10M = 4;
  localparam int BIT_NULL_VID_REP = 3;
  localparam int STORM_HI_MSB     = 2;
  localparam int STORM_HI_WIDTH   = 3;
  localparam int STORM_THR_WIDTH  = 11;
  localparam int VID_WIDTH        = 12;
  // writable bits of the misc register; the rest read zero
  localparam logic [7:0] MISC_RW_MASK = 8'h4B;

  // ==========================================================================
  // reset values and the null VID value
  localparam logic [2:0] RST_STORM_HI        = 3'h0;
  localparam logic [7:0] RST_STORM_RATE_LOW  = 8'h4A;
  localparam logic [7:0] RST_FACTORY_TEST_A  = 8'h00;
  localparam logic [7:0] RST_FACTORY_TEST_B  = 8'h4C;
  localparam logic [7:0] RST_FACTORY_TEST_C  = 8'h00;
  localparam logic [7:0] RST_MISC_GLOBAL_CFG = 8'h00;
  localparam logic [11:0] NULL_VID           = 12'h000;

  // ==========================================================================
  // timing
  localparam longint CLK_HZ          = 10_000_000;
  localparam longint PERIOD_100M_MS  = 50;
  localparam longint PERIOD_10M_MS   = 500;
  localparam longint PERIOD_100M_CYC = PERIOD_100M_MS * CLK_HZ / 1000;
  localparam longint PERIOD_10M_CYC  = PERIOD_10M_MS * CLK_HZ / 1000;

endpackage

/* File: logic/storm_period_timer.sv */
// Purpose: free-running period timer, one-cycle tick at the end of each period
// Assumes: PERIOD_CYCLES of at least 2
// Notes:   tick is registered
`timescale 1ns/100ps
module storm_period_timer #(
  parameter int PERIOD_CYCLES = 500000
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // period end
  output logic      tick_out
);

  localparam int CW = $clog2(PERIOD_CYCLES);
  localparam logic [CW-1:0] LAST = CW'(PERIOD_CYCLES - 1);

  if (PERIOD_CYCLES < 2) begin : g_bad_period
    $error("period too short");
  end

  logic [CW-1:0] count;
  wire           at_end = (count == LAST);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count    <= '0;
      tick_out <= 1'b0;
    end else begin
      count    <= at_end ? '0 : count + 1'b1;
      tick_out <= at_end;
    end
  end

endmodule

/* File: logic/switch_global_storm_config.sv */
// Purpose: speed / null-VID / storm threshold registers plus per-port storm limiter
// Assumes: register port and block pulses are synchronous to clk_in
// Notes:   drop flag lags the counted block by one cycle
//
// Summary of operation
// - speed bit 1 means 10M, 0 means 100M
// - speed bit reset value follows strap pin
// - null VID replaced by port VID when enabled
// - threshold is hi three bits plus low byte
// - threshold counts 64-byte broadcast blocks per port
// - period 50 ms at 100M, 500 ms at 10M
`timescale 1ns/100ps
module switch_global_storm_config #(
  parameter int     NUM_PORTS       = 5,
  parameter longint PERIOD_100M_CYC = storm_cfg_pkg::PERIOD_100M_CYC,
  parameter longint PERIOD_10M_CYC  = storm_cfg_pkg::PERIOD_10M_CYC
) (
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  // strap pin
  input  wire logic                   speed_strap_pin_in,
  // management register port
  input  wire logic [7:0]             reg_addr_in,
  input  wire logic                   reg_wr_in,
  input  wire logic [7:0]             reg_wdata_in,
  input  wire logic                   reg_rd_in,
  output logic      [7:0]             reg_rdata_out,
  output logic                        reg_rvalid_out,
  // port-5 switch mac
  output logic                        port5_mac_10m_out,
  // null vid replacement
  input  wire logic                   vid_valid_in,
  input  wire logic [11:0]            frame_vid_in,
  input  wire logic [11:0]            port_vid_in,
  output logic      [11:0]            vid_out,
  output logic                        vid_valid_out,
  // storm limiter, per port
  input  wire logic [NUM_PORTS-1:0]   port_is_10m_in,
  input  wire logic [NUM_PORTS-1:0]   bcast_block_in,
  output logic      [NUM_PORTS-1:0]   bcast_drop_out,
  output logic      [10:0]            storm_threshold_out
);

  // ==========================================================================
  // elaboration checks
  // port count capped so the generate loop stays small
  if (NUM_PORTS < 1 || NUM_PORTS > 8) begin : g_bad_ports
    $error("NUM_PORTS out of range");
  end
  if (PERIOD_100M_CYC < 2) begin : g_bad_short
    $error("100M period too short");
  end
  if (PERIOD_10M_CYC < PERIOD_100M_CYC) begin : g_bad_order
    $error("10M period shorter than 100M");
  end
  // timers take an int count; longer periods would wrap silently
  if (PERIOD_10M_CYC > 64'h0000_0000_7FFF_FFFF) begin : g_bad_long
    $error("10M period too long for the timer");
  end

  // ==========================================================================
  // strap synchroniser and capture
  logic strap_meta;
  logic strap_sync;
  logic strap_pending;

  // no reset on the chain so the pin level is settled when reset releases
  always_ff @(posedge clk_in) begin
    strap_meta <= speed_strap_pin_in;
    strap_sync <= strap_meta;
  end

  // ==========================================================================
  // registers
  logic                 speed_10m;
  logic                 null_vid_rep;
  logic [2:0]           storm_hi;
  logic [7:0]           storm_rate_low;
  logic [7:0]           misc_global_config;

  // one write decoder for every writable offset
  function automatic logic wr_hit(input logic       wr,
                                  input logic [7:0] addr,
                                  input logic [7:0] ofs);
    return wr && (addr == ofs);
  endfunction

  wire wr_hi   = wr_hit(reg_wr_in, reg_addr_in, storm_cfg_pkg::OFS_SPEED_VID_STORM_HI);
  wire wr_low  = wr_hit(reg_wr_in, reg_addr_in, storm_cfg_pkg::OFS_STORM_RATE_LOW);
  wire wr_misc = wr_hit(reg_wr_in, reg_addr_in, storm_cfg_pkg::OFS_MISC_GLOBAL_CONFIG);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      speed_10m          <= 1'b0;
      strap_pending      <= 1'b1;
      null_vid_rep       <= 1'b0;
      storm_hi           <= storm_cfg_pkg::RST_STORM_HI;
      storm_rate_low     <= storm_cfg_pkg::RST_STORM_RATE_LOW;
      misc_global_config <= storm_cfg_pkg::RST_MISC_GLOBAL_CFG;
    end else begin
      strap_pending <= 1'b0;
      // strap wins over a write landing on the first edge after reset
      if (strap_pending) begin
        speed_10m <= strap_sync;
      end else if (wr_hi) begin
        speed_10m <= reg_wdata_in[storm_cfg_pkg::BIT_P5_SPEED_10M];
      end
      if (wr_hi) begin
        null_vid_rep <= reg_wdata_in[storm_cfg_pkg::BIT_NULL_VID_REP];
        storm_hi     <= reg_wdata_in[storm_cfg_pkg::STORM_HI_MSB:0];
      end
      if (wr_low) begin
        storm_rate_low <= reg_wdata_in;
      end
      if (wr_misc) begin
        misc_global_config <= reg_wdata_in & storm_cfg_pkg::MISC_RW_MASK;
      end
    end
  end

  // ==========================================================================
  // read path; unmapped offsets and bits outside this slice read zero
  logic [7:0] next_rdata;
  // a read and a write in one cycle return the old value

  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr_in)
      storm_cfg_pkg::OFS_SPEED_VID_STORM_HI: next_rdata = {3'h0, speed_10m, null_vid_rep,
                                                           storm_hi};
      storm_cfg_pkg::OFS_STORM_RATE_LOW:     next_rdata = storm_rate_low;
      storm_cfg_pkg::OFS_FACTORY_TEST_A:     next_rdata = storm_cfg_pkg::RST_FACTORY_TEST_A;
      storm_cfg_pkg::OFS_FACTORY_TEST_B:     next_rdata = storm_cfg_pkg::RST_FACTORY_TEST_B;
      storm_cfg_pkg::OFS_FACTORY_TEST_C:     next_rdata = storm_cfg_pkg::RST_FACTORY_TEST_C;
      storm_cfg_pkg::OFS_MISC_GLOBAL_CONFIG: next_rdata = misc_global_config;
      default:                               next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reg_rdata_out  <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= next_rdata;
      end
    end
  end

  assign port5_mac_10m_out = speed_10m;

  // ==========================================================================
  // null vid replacement
  wire        vid_is_null = (frame_vid_in == storm_cfg_pkg::NULL_VID);
  wire [11:0] next_vid    = (null_vid_rep && vid_is_null) ? port_vid_in
                                                          : frame_vid_in;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      vid_out       <= 12'h000;
      vid_valid_out <= 1'b0;
    end else begin
      vid_valid_out <= vid_valid_in;
      if (vid_valid_in) begin
        vid_out <= next_vid;
      end
    end
  end

  // ==========================================================================
  // storm limiter
  wire [10:0] threshold = {storm_hi, storm_rate_low};
  assign storm_threshold_out = threshold;

  logic tick_100m;
  logic tick_10m;

  // two timers rather than one divided: keeps both periods exact if retuned
  storm_period_timer #(
    .PERIOD_CYCLES (int'(PERIOD_100M_CYC))
  ) u_timer_100m (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .tick_out (tick_100m)
  );

  storm_period_timer #(
    .PERIOD_CYCLES (int'(PERIOD_10M_CYC))
  ) u_timer_10m (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .tick_out (tick_10m)
  );

  // per-port drop flags gathered on a net so each bit has one driver
  wire [NUM_PORTS-1:0] drop_vec;

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      logic [10:0] blocks;
      logic        drop;
      wire         period_end = port_is_10m_in[p] ? tick_10m : tick_100m;
      wire         at_limit   = (blocks >= threshold);
      // blocks arriving at the limit are discarded, not counted
      wire         take       = bcast_block_in[p] && !at_limit;
      // a block in the tick cycle opens the new period instead of being lost
      wire         start_take = bcast_block_in[p] && (threshold != 11'h000);
      wire [10:0]  restart    = {10'h000, start_take};
      wire [10:0]  next_blocks = period_end ? restart : (take ? blocks + 11'h001 : blocks);

      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          blocks <= 11'h000;
          drop   <= 1'b0;
        end else begin
          blocks <= next_blocks;
          drop   <= (next_blocks >= threshold);
        end
      end

      assign drop_vec[p] = drop;
    end
  endgenerate

  assign bcast_drop_out = drop_vec;

endmodule

/* File: tb/storm_cfg_assertions.sv */
// Purpose: port-level checks for the speed / vid / storm register slice
// Assumes: single clock domain, sync reset
// Notes:   drop checks watch port 0 only
`timescale 1ns/100ps
module storm_cfg_checker #(
  parameter int NUM_PORTS = 5
) (
  input wire logic                 clk_in,
  input wire logic                 rst_in,
  input wire logic [7:0]           reg_addr_in,
  input wire logic                 reg_wr_in,
  input wire logic [7:0]           reg_wdata_in,
  input wire logic                 reg_rd_in,
  input wire logic                 reg_rvalid_out,
  input wire logic                 port5_mac_10m_out,
  input wire logic                 vid_valid_in,
  input wire logic [11:0]          frame_vid_in,
  input wire logic [11:0]          vid_out,
  input wire logic                 vid_valid_out,
  input wire logic [NUM_PORTS-1:0] bcast_block_in,
  input wire logic [NUM_PORTS-1:0] bcast_drop_out,
  input wire logic [10:0]          storm_threshold_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire hi_wr = reg_wr_in && reg_addr_in == storm_cfg_pkg::OFS_SPEED_VID_STORM_HI;
  wire lo_wr = reg_wr_in && reg_addr_in == storm_cfg_pkg::OFS_STORM_RATE_LOW;
  // ==========================================
  // properties
  property p_rd_ack; reg_rd_in |=> reg_rvalid_out; endproperty
  property p_rd_idle; !reg_rd_in |=> !reg_rvalid_out; endproperty
  property p_lo_wr; lo_wr |=> storm_threshold_out[7:0] == $past(reg_wdata_in); endproperty
  property p_hi_wr; hi_wr |=> storm_threshold_out[10:8] == $past(reg_wdata_in[2:0]); endproperty
  // strap load wins on the first edge after release
  property p_speed_wr;
    hi_wr && !$past(rst_in) |=> port5_mac_10m_out == $past(reg_wdata_in[4]);
  endproperty
  property p_vid_pass;
    vid_valid_in && frame_vid_in != 12'h000 |=> vid_valid_out && vid_out == $past(frame_vid_in);
  endproperty
  property p_vid_idle; !vid_valid_in |=> !vid_valid_out; endproperty
  property p_drop_cause;
    $rose(bcast_drop_out[0]) |-> $past(bcast_block_in[0]) || storm_threshold_out == 11'h000;
  endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("read not answered");
  a_rd_idle: assert property (p_rd_idle) else $error("stray read valid");
  a_lo_wr: assert property (p_lo_wr) else $error("low threshold not written");
  a_hi_wr: assert property (p_hi_wr) else $error("high threshold not written");
  a_speed_wr: assert property (p_speed_wr) else $error("speed bit wrong");
  a_vid_pass: assert property (p_vid_pass) else $error("vid not passed");
  a_vid_idle: assert property (p_vid_idle) else $error("stray vid valid");
  a_drop_cause: assert property (p_drop_cause) else $error("drop without block");
  c_drop: cover property ($rose(bcast_drop_out[0]));
  c_vid: cover property (vid_valid_out && vid_out != 12'h000);
  c_speed: cover property ($fell(port5_mac_10m_out));
endmodule

bind switch_global_storm_config storm_cfg_checker #(.NUM_PORTS(NUM_PORTS)) checker_inst (
  .clk_in, .rst_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rd_in, .reg_rvalid_out,
  .port5_mac_10m_out, .vid_valid_in, .frame_vid_in, .vid_out, .vid_valid_out,
  .bcast_block_in, .bcast_drop_out, .storm_threshold_out);

/* File: tb/tb.sv */
// Purpose: directed bench for the speed / vid / storm register slice
// Assumes: periods shortened to 20 and 200 cycles
// Notes:   inputs change on the falling edge
`timescale 1ns/100ps
module tb;
  logic        clk_in, rst_in, strap, wr, rd, rvalid, p5, vv_in, vv_out;
  logic [7:0]  addr, wdata, rdata;
  logic [11:0] fvid, pvid, vid;
  logic [4:0]  is10, blk, drop;
  logic [10:0] thr;
  int          n_fail, checked;
  switch_global_storm_config #(.PERIOD_100M_CYC(20), .PERIOD_10M_CYC(200))
  switch_global_storm_config_inst (
    .clk_in(clk_in), .rst_in(rst_in), .speed_strap_pin_in(strap), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .port5_mac_10m_out(p5), .vid_valid_in(vv_in),
    .frame_vid_in(fvid), .port_vid_in(pvid), .vid_out(vid), .vid_valid_out(vv_out),
    .port_is_10m_in(is10), .bcast_block_in(blk), .bcast_drop_out(drop),
    .storm_threshold_out(thr));
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // ==========================================
  // tasks
  task automatic wrap_up;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic reset(input logic s);
    strap = s;
    rst_in = 1'b1;
    repeat (3) @(negedge clk_in);
    rst_in = 1'b0;
    @(negedge clk_in);
    chk(p5, s);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_in);
    wr = 1'b0;
    @(negedge clk_in);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    rd = 1'b1;
    @(negedge clk_in);
    rd = 1'b0;
    chk({rvalid, rdata}, {1'b1, e});
    @(negedge clk_in);
  endtask
  task automatic vidc(input logic [11:0] f, input logic [11:0] e);
    fvid = f;
    pvid = 12'h123;
    vv_in = 1'b1;
    @(negedge clk_in);
    vv_in = 1'b0;
    chk({vv_out, vid}, {1'b1, e});
    @(negedge clk_in);
  endtask
  task automatic guard(input int c);
    if (c >= 400) begin
      n_fail++;
      wrap_up;
    end
  endtask
  // saturate, sync to a period start, then count blocks to drop and cycles to next start
  task automatic storm(input int p, input int per);
    int c, n;
    for (c = 0; c < 400 && !drop[p]; c++) begin
      blk[p] = 1'b1;
      @(negedge clk_in);
    end
    blk[p] = 1'b0;
    guard(c);
    for (c = 0; c < 400 && drop[p]; c++) @(negedge clk_in);
    guard(c);
    n = 0;
    for (c = 0; c < 400 && !drop[p]; c++) begin
      blk[p] = 1'b1;
      n++;
      @(negedge clk_in);
    end
    blk[p] = 1'b0;
    for (; c < 400 && drop[p]; c++) @(negedge clk_in);
    guard(c);
    chk(n, 3);
    chk(c, per);
  endtask
  // ==========================================
  // sequence
  initial begin
    logic [7:0] rv [6];
    rv = '{8'h00, 8'h4A, 8'h00, 8'h4C, 8'h00, 8'h00};
    {rst_in, strap, wr, rd, vv_in, is10, blk} = '0;
    {addr, wdata, fvid, pvid} = '0;
    reset(1'b1);
    rreg(8'h06, 8'h10);
    reset(1'b0);
    for (int i = 0; i < 6; i++) rreg(8'h06 + 8'(i), rv[i]);
    chk(thr, 11'h04A);
    rreg(8'h20, 8'h00);
    wreg(8'h08, 8'hFF);
    rreg(8'h08, 8'h00);
    wreg(8'h0B, 8'hFF);
    rreg(8'h0B, 8'h4B);
    wreg(8'h06, 8'h1A);
    chk(p5, 1'b1);
    chk(thr, 11'h24A);
    vidc(12'h000, 12'h123);
    vidc(12'h005, 12'h005);
    wreg(8'h06, 8'h00);
    chk(p5, 1'b0);
    vidc(12'h000, 12'h000);
    wreg(8'h07, 8'h03);
    chk(thr, 11'h003);
    is10 = 5'b00010;
    storm(0, 20);
    storm(1, 200);
    wrap_up;
  end
endmodule
